// File: src/ddsp_serial_port.sv
/*
  Serial control port and 32-bit control register of a direct digital
  synthesizer. The system clock oversamples serial clock, select, data,
  resync and update pins; only the control register is stored.
  Assumes the serial clock is well below a quarter of the system clock.
*/
`timescale 1ns/1ps
module ddsp_serial_port
(
  input  wire logic              clock,
  input  wire logic              reset_n,
  input  wire logic              sclk,
  input  wire logic              port_select_n,
  input  wire logic              sdio_in,
  output logic                   sdio_out,
  output logic                   sdio_oe,
  output logic                   serial_read_out,
  output logic                   serial_read_out_oe,
  input  wire logic              io_resync,
  input  wire logic              update_strobe_in,
  output logic                   update_strobe_out,
  output logic                   update_strobe_oe,
  output logic                   comparator_pd,
  output logic                   control_dac_pd,
  output logic                   full_dac_pd,
  output logic                   digital_clock_stop,
  output logic                   vco_high_gain,
  output logic                   pll_bypass,
  output logic [4:0]             pll_multiplier,
  output logic                   acc1_clear_pulse,
  output logic                   acc_hold_clear,
  output logic                   triangle_sweep,
  output ddsp_pkg::ddsp_mode_e   op_mode,
  output logic                   isinc_bypass,
  output logic                   shape_key_enable,
  output logic                   shape_key_internal,
  output logic                   device_halted
);
  import ddsp_pkg::*;

  logic        rst_meta_reg;
  logic        rst_n_reg;
  logic [4:0]  sync_vec;
  logic        sclk_s;
  logic        cs_n_s;
  logic        sdi_s;
  logic        resync_s;
  logic        upd_s;
  logic        sclk_d_reg;
  logic        upd_d_reg;
  logic        rise_ok;
  logic        fall_ok;
  ddsp_phase_e phase_reg;
  logic [5:0]  bit_cnt_reg;
  logic [5:0]  data_len_reg;
  logic [7:0]  instr_reg;
  logic [7:0]  instr_next;
  logic        read_reg;
  logic [3:0]  addr_reg;
  logic [31:0] rx_sr_reg;
  logic [31:0] tx_sr_reg;
  logic        tx_bit_reg;
  logic        instr_end;
  logic        data_end;
  logic        write_done_reg;
  logic        write_done_d_reg;
  logic [31:0] shadow_reg;
  logic [31:0] cr_reg;
  logic        apply;
  logic        ext_update;
  logic        int_update;
  logic [7:0]  upd_cnt_reg;
  logic        acc1_reg;
  logic        halted_reg;
  logic        lsb_first;
  logic        read_phase;

  // ===========================================================================
  // Reset release
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // ===========================================================================
  // Pin synchronisers
  ddsp_sync
  #(
    .WIDTH     (5),
    .RESET_VAL (SYNC_RESET_VAL)
  )
  ddsp_sync_inst
  (
    .clock    (clock),
    .reset_n  (rst_n_reg),
    .async_in ({update_strobe_in, port_select_n, io_resync, sdio_in, sclk}),
    .sync_out (sync_vec)
  );

  assign sclk_s   = sync_vec[0];
  assign sdi_s    = sync_vec[1];
  assign resync_s = sync_vec[2];
  assign cs_n_s   = sync_vec[3];
  assign upd_s    = sync_vec[4];

  always_ff @(posedge clock or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      sclk_d_reg <= 1'b0;
      upd_d_reg  <= 1'b0;
    end
    else
    begin
      sclk_d_reg <= sclk_s;
      upd_d_reg  <= upd_s;
    end
  end

  // ===========================================================================
  // Serial edges
  assign lsb_first = cr_reg[CR_LSB_FIRST];
  assign rise_ok   = sclk_s & ~sclk_d_reg & ~cs_n_s & ~resync_s;
  assign fall_ok   = ~sclk_s & sclk_d_reg & ~cs_n_s & ~resync_s;
  assign instr_next = lsb_first ? {sdi_s, instr_reg[7:1]}
                                : {instr_reg[6:0], sdi_s};
  assign instr_end = rise_ok && (phase_reg == PH_INSTR) && (bit_cnt_reg == INSTR_LAST_BIT);
  assign data_end  = rise_ok && (phase_reg == PH_DATA)
                     && (bit_cnt_reg == data_len_reg - 6'd1);

  // ===========================================================================
  // Port sequencer
  always_ff @(posedge clock or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      phase_reg    <= PH_INSTR;
      bit_cnt_reg  <= 6'd0;
      data_len_reg <= 6'd8;
      instr_reg    <= 8'h00;
      read_reg     <= 1'b0;
      addr_reg     <= 4'h0;
    end
    else if (halted_reg)
    begin
      phase_reg <= PH_HALT;
    end
    else if (resync_s)
    begin
      phase_reg   <= PH_INSTR;
      bit_cnt_reg <= 6'd0;
    end
    else if (rise_ok)
    begin
      case (phase_reg)
        PH_INSTR:
        begin
          instr_reg <= instr_next;
          if (instr_end)
          begin
            phase_reg    <= PH_DATA;
            bit_cnt_reg  <= 6'd0;
            read_reg     <= instr_next[INSTR_RW_BIT];
            addr_reg     <= instr_next[3:0];
            data_len_reg <= ddsp_data_bits(instr_next[3:0]);
          end
          else
          begin
            bit_cnt_reg <= bit_cnt_reg + 6'd1;
          end
        end
        PH_DATA:
        begin
          if (data_end)
          begin
            phase_reg   <= PH_INSTR;
            bit_cnt_reg <= 6'd0;
          end
          else
          begin
            bit_cnt_reg <= bit_cnt_reg + 6'd1;
          end
        end
        default:
        begin
          phase_reg <= PH_HALT;
        end
      endcase
    end
  end

  // ===========================================================================
  // Receive shifter and write completion
  always_ff @(posedge clock or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      rx_sr_reg        <= 32'h0000_0000;
      write_done_reg   <= 1'b0;
      write_done_d_reg <= 1'b0;
    end
    else
    begin
      write_done_d_reg <= write_done_reg;
      write_done_reg   <= data_end && !read_reg && (addr_reg == CTRL_SER_ADDR) && !halted_reg;
      if (rise_ok && (phase_reg == PH_DATA) && !halted_reg)
      begin
        rx_sr_reg <= lsb_first ? {sdi_s, rx_sr_reg[31:1]}
                               : {rx_sr_reg[30:0], sdi_s};
      end
    end
  end

  // ===========================================================================
  // Transmit shifter
  always_ff @(posedge clock or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      tx_sr_reg  <= 32'h0000_0000;
      tx_bit_reg <= 1'b0;
    end
    else if (instr_end && !halted_reg)
    begin
      tx_sr_reg <= (instr_next[3:0] == CTRL_SER_ADDR) ? cr_reg : 32'h0000_0000;
    end
    else if (fall_ok && read_phase)
    begin
      tx_bit_reg <= lsb_first ? tx_sr_reg[0] : tx_sr_reg[31];
      tx_sr_reg  <= lsb_first ? {1'b0, tx_sr_reg[31:1]}
                              : {tx_sr_reg[30:0], 1'b0};
    end
  end

  // ===========================================================================
  // Data pin drivers
  assign read_phase         = (phase_reg == PH_DATA) && read_reg;
  assign sdio_out           = tx_bit_reg;
  assign serial_read_out    = tx_bit_reg;
  assign sdio_oe            = read_phase && !cs_n_s && !cr_reg[CR_SDO_ACTIVE];
  assign serial_read_out_oe = read_phase && !cs_n_s && cr_reg[CR_SDO_ACTIVE];

  // ===========================================================================
  // Shadow register
  always_ff @(posedge clock or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      shadow_reg <= CR_RESET;
    end
    else if (write_done_reg)
    begin
      shadow_reg <= rx_sr_reg & CR_WRITE_MASK;
    end
  end

  // ===========================================================================
  // Update strobe
  assign int_update = cr_reg[CR_INT_UPDATE];
  assign ext_update = !int_update && upd_s && !upd_d_reg;
  assign apply      = !halted_reg && (ext_update || (int_update && write_done_d_reg));

  always_ff @(posedge clock or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      upd_cnt_reg <= 8'h00;
    end
    else if (int_update && write_done_d_reg)
    begin
      upd_cnt_reg <= 8'(UPD_PULSE_CYC);
    end
    else if (upd_cnt_reg != 8'h00)
    begin
      upd_cnt_reg <= upd_cnt_reg - 8'h01;
    end
  end

  assign update_strobe_oe  = int_update;
  assign update_strobe_out = int_update && (upd_cnt_reg != 8'h00);

  // ===========================================================================
  // Control register
  always_ff @(posedge clock or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      cr_reg   <= CR_RESET;
      acc1_reg <= 1'b0;
    end
    else
    begin
      acc1_reg <= apply && shadow_reg[CR_CLR_ACC1];
      if (apply)
      begin
        cr_reg <= shadow_reg;
      end
      else if (cr_reg[CR_CLR_ACC1])
      begin
        cr_reg[CR_CLR_ACC1] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      halted_reg <= 1'b0;
    end
    else if (cr_reg[CR_HALT])
    begin
      halted_reg <= 1'b1;
    end
  end

  // ===========================================================================
  // Control outputs
  assign comparator_pd      = cr_reg[CR_CMP_PD];
  assign control_dac_pd     = cr_reg[CR_CDAC_PD];
  assign full_dac_pd        = cr_reg[CR_FULL_DAC_PD];
  assign digital_clock_stop = cr_reg[CR_DIG_PD] | halted_reg;
  assign vco_high_gain      = cr_reg[CR_VCO_GAIN];
  assign pll_bypass         = cr_reg[CR_PLL_BYP];
  assign pll_multiplier     = cr_reg[CR_MULT_HI:CR_MULT_LO];
  assign acc1_clear_pulse   = acc1_reg;
  assign acc_hold_clear     = cr_reg[CR_CLR_ACC];
  assign triangle_sweep     = cr_reg[CR_TRIANGLE];
  assign op_mode            = ddsp_mode_e'(cr_reg[CR_MODE_HI:CR_MODE_LO]);
  assign isinc_bypass       = cr_reg[CR_ISINC_BYP];
  assign shape_key_enable   = cr_reg[CR_SHAPE_EN];
  assign shape_key_internal = cr_reg[CR_SHAPE_INT];
  assign device_halted      = halted_reg;

endmodule

// File: include/ddsp_pkg.sv
/*
  Constants, field positions, reset values and types for the serial control
  port of the synthesizer and its 32-bit control register.
  Assumes a 125 MHz system clock that oversamples the serial pins.
*/
package ddsp_pkg;

  // ===========================================================================
  // Timing
  localparam int CLK_PERIOD_NS  = 8;
  localparam int UPD_PULSE_NS   = 64;
  localparam int UPD_PULSE_CYC  = (UPD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ===========================================================================
  // Register map
  localparam logic [7:0]  CTRL_BYTE_ADDR_FIRST = 8'h1D;
  localparam logic [7:0]  CTRL_BYTE_ADDR_LAST  = 8'h20;
  localparam logic [3:0]  CTRL_SER_ADDR        = 4'h7;
  localparam logic [31:0] CR_RESET             = 32'h0060_0000;
  localparam logic [31:0] CR_WRITE_MASK        = 32'h1F7F_EF73;

  // ===========================================================================
  // Control register fields
  localparam int CR_SDO_ACTIVE  = 0;
  localparam int CR_LSB_FIRST   = 1;
  localparam int CR_SHAPE_INT   = 4;
  localparam int CR_SHAPE_EN    = 5;
  localparam int CR_ISINC_BYP   = 6;
  localparam int CR_INT_UPDATE  = 8;
  localparam int CR_MODE_LO     = 9;
  localparam int CR_MODE_HI     = 11;
  localparam int CR_TRIANGLE    = 13;
  localparam int CR_CLR_ACC     = 14;
  localparam int CR_CLR_ACC1    = 15;
  localparam int CR_MULT_LO     = 16;
  localparam int CR_MULT_HI     = 20;
  localparam int CR_PLL_BYP     = 21;
  localparam int CR_VCO_GAIN    = 22;
  localparam int CR_DIG_PD      = 24;
  localparam int CR_FULL_DAC_PD = 25;
  localparam int CR_CDAC_PD     = 26;
  localparam int CR_HALT        = 27;
  localparam int CR_CMP_PD      = 28;

  // ===========================================================================
  // Instruction byte and pin synchroniser reset value
  localparam int         INSTR_RW_BIT   = 7;
  localparam logic [5:0] INSTR_LAST_BIT = 6'd7;
  localparam logic [4:0] SYNC_RESET_VAL = 5'b01000;

  // ===========================================================================
  // Types
  typedef enum logic [2:0]
  {
    MODE_SINGLE_TONE = 3'h0,
    MODE_FSK         = 3'h1,
    MODE_RAMPED_FSK  = 3'h2,
    MODE_CHIRP       = 3'h3,
    MODE_BPSK        = 3'h4
  } ddsp_mode_e;

  typedef enum logic [1:0]
  {
    PH_INSTR = 2'b00,
    PH_DATA  = 2'b01,
    PH_HALT  = 2'b11
  } ddsp_phase_e;

  // Data bits per serial address
  function automatic logic [5:0] ddsp_data_bits(input logic [3:0] addr);
    logic [5:0] bits;
    bits = 6'd8;
    case (addr)
      4'h0, 4'h1, 4'h8, 4'hB: bits = 6'd16;
      4'h2, 4'h3, 4'h4:       bits = 6'd48;
      4'h5, 4'h7:             bits = 6'd32;
      4'h6:                   bits = 6'd24;
      default:                bits = 6'd8;
    endcase
    return bits;
  endfunction

endpackage

// File: src/ddsp_sync.sv
/*
  Two flip-flop synchroniser for a group of single-bit levels.
  Assumes each bit is an independent level from outside the clock domain.
*/
`timescale 1ns/1ps
module ddsp_sync
#(
  parameter int         WIDTH     = 1,
  parameter logic [4:0] RESET_VAL = 5'h00
)
(
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // ===========================================================================
  // Two stages
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_reg <= RESET_VAL[WIDTH-1:0];
      sync_out <= RESET_VAL[WIDTH-1:0];
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

// File: tb/ddsp_serial_port_asserts.sv
/*
  Checker for the serial control port: pin enables, strobes and halt.
  Assumes it is bound to ddsp_serial_port and sees only its ports.
*/
`timescale 1ns/1ps
module ddsp_port_chk
(
  input wire logic       clock,
  input wire logic       reset_n,
  input wire logic       port_select_n,
  input wire logic       io_resync,
  input wire logic       update_strobe_in,
  input wire logic       sdio_oe,
  input wire logic       serial_read_out_oe,
  input wire logic       update_strobe_out,
  input wire logic       update_strobe_oe,
  input wire logic       acc1_clear_pulse,
  input wire logic       device_halted,
  input wire logic       digital_clock_stop,
  input wire logic       vco_high_gain,
  input wire logic       pll_bypass,
  input wire logic [4:0] pll_multiplier
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // ======
  // Assertions
  a_select_hiz:
    assert property (port_select_n [*6] |-> !sdio_oe && !serial_read_out_oe)
    else $error("data output driven while deselected");
  a_single_driver:
    assert property (!(sdio_oe && serial_read_out_oe))
    else $error("both data outputs driven");
  a_resync_quiet:
    assert property (io_resync [*6] |-> !sdio_oe && !serial_read_out_oe)
    else $error("data output driven during resync");
  a_clear_single:
    assert property (acc1_clear_pulse |=> !acc1_clear_pulse)
    else $error("clear pulse longer than one cycle");
  a_upd_width:
    assert property ($rose(update_strobe_out) |-> update_strobe_out [*8] ##1 !update_strobe_out)
    else $error("internal update pulse width wrong");
  a_upd_gated:
    assert property (update_strobe_out |-> update_strobe_oe)
    else $error("update driven while pin is an input");
  a_apply_cause:
    assert property ($changed(pll_multiplier) |->
      $past(update_strobe_in, 3) || update_strobe_oe || $past(update_strobe_oe))
    else $error("control changed without an update");
  a_halt_sticky:
    assert property (device_halted |=> device_halted)
    else $error("halt released without reset");
  a_halt_clocks:
    assert property (device_halted |-> digital_clock_stop)
    else $error("clocks running while halted");
  a_pll_reset:
    assert property ($rose(reset_n) |-> vco_high_gain && pll_bypass)
    else $error("pll bits not set after reset");
  c_upd: cover property ($rose(update_strobe_out));
  c_clr: cover property (acc1_clear_pulse);
  c_halt: cover property ($rose(device_halted));
  c_sdo: cover property (serial_read_out_oe);
endmodule

bind ddsp_serial_port ddsp_port_chk ddsp_port_chk_inst
(
  .clock(clock), .reset_n(reset_n), .port_select_n(port_select_n),
  .io_resync(io_resync), .update_strobe_in(update_strobe_in), .sdio_oe(sdio_oe),
  .serial_read_out_oe(serial_read_out_oe), .update_strobe_out(update_strobe_out),
  .update_strobe_oe(update_strobe_oe), .acc1_clear_pulse(acc1_clear_pulse),
  .device_halted(device_halted), .digital_clock_stop(digital_clock_stop),
  .vco_high_gain(vco_high_gain), .pll_bypass(pll_bypass), .pll_multiplier(pll_multiplier)
);

// File: tb/ddsp_host_model.sv
/*
  System controller model driving the serial port at 8 MHz.
  Assumes the bench resolves the shared data wire into read_line.
*/
`timescale 1ns/1ps
module ddsp_host_model
(
  output logic      sclk,
  output logic      port_select_n,
  output logic      host_data,
  output logic      host_data_oe,
  output logic      io_resync,
  input  wire logic read_line
);
  initial
  begin
    sclk = 1'b0;
    port_select_n = 1'b1;
    host_data = 1'b0;
    host_data_oe = 1'b0;
    io_resync = 1'b0;
  end
  // ======
  // One cycle: instruction then nb bytes; brk pauses or aborts at that bit
  task automatic frame(input logic [7:0] ins, input logic [47:0] d, input int nb,
                       input logic lsb, input int brk, input logic ab, output logic [47:0] rd);
    int k;
    int nd;
    nd = nb * 8;
    rd = '0;
    port_select_n = 1'b0;
    host_data_oe = 1'b1;
    #60;
    for (k = 0; k < 8 + nd; k++)
    begin
      if (k == brk && ab)
      begin
        io_resync = 1'b1;
        #400;
        io_resync = 1'b0;
        #200;
        break;
      end
      if (k == brk)
      begin
        port_select_n = 1'b1;
        repeat (3)
        begin
          #62.5 sclk = 1'b1;
          #62.5 sclk = 1'b0;
        end
        port_select_n = 1'b0;
        #100;
      end
      sclk = 1'b0;
      if (k < 8)
        host_data = ins[lsb ? k : 7 - k];
      else
      begin
        host_data_oe = !ins[7];
        host_data = d[lsb ? k - 8 : nd - 1 - (k - 8)];
      end
      #62.5 sclk = 1'b1;
      if (k >= 8)
        rd[lsb ? k - 8 : nd - 1 - (k - 8)] = read_line;
      #62.5;
    end
    sclk = 1'b0;
    host_data_oe = 1'b0;
    #100 port_select_n = 1'b1;
    #200;
  endtask
endmodule

// File: tb/ddsp_serial_port_tb.sv
/*
  Self-checking bench for the serial port and control register.
  Assumes the package, the design and the host model are compiled first.
*/
`timescale 1ns/1ps
module ddsp_serial_port_tb;
  import ddsp_pkg::*;
  localparam logic [31:0] RSV = 32'hE080_108C;
  localparam logic [31:0] OBS = 32'h177F_6F70;
  logic clock = 1'b0;
  logic reset_n, update_strobe_in, sclk, port_select_n, io_resync, host_data, host_data_oe;
  logic sdio_out, sdio_oe, serial_read_out, serial_read_out_oe, update_strobe_out;
  logic update_strobe_oe, comparator_pd, control_dac_pd, full_dac_pd, digital_clock_stop;
  logic vco_high_gain, pll_bypass, acc1_clear_pulse, acc_hold_clear, triangle_sweep;
  logic isinc_bypass, shape_key_enable, shape_key_internal, device_halted;
  logic [4:0] pll_multiplier;
  ddsp_mode_e op_mode;
  wire logic sdio_in;
  wire logic read_line;
  logic junk = 1'b0;
  logic [31:0] exp_q[$];
  logic [31:0] got, exp_w, seed, cur;
  int fail_count = 0;
  int samples_checked = 0;
  int clr_cnt = 0;
  event got_ev;

  always #4 clock = ~clock;
  always @(posedge clock) junk <= ~junk;
  always @(posedge clock) if (acc1_clear_pulse === 1'b1) clr_cnt++;
  assign sdio_in = sdio_oe ? sdio_out : (host_data_oe ? host_data : junk);
  assign read_line = cur[0] ? (serial_read_out_oe ? serial_read_out : junk) : sdio_in;

  ddsp_serial_port ddsp_serial_port_inst
  (
    .clock(clock), .reset_n(reset_n), .sclk(sclk), .port_select_n(port_select_n),
    .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .serial_read_out(serial_read_out), .serial_read_out_oe(serial_read_out_oe),
    .io_resync(io_resync), .update_strobe_in(update_strobe_in),
    .update_strobe_out(update_strobe_out), .update_strobe_oe(update_strobe_oe),
    .comparator_pd(comparator_pd), .control_dac_pd(control_dac_pd),
    .full_dac_pd(full_dac_pd), .digital_clock_stop(digital_clock_stop),
    .vco_high_gain(vco_high_gain), .pll_bypass(pll_bypass),
    .pll_multiplier(pll_multiplier), .acc1_clear_pulse(acc1_clear_pulse),
    .acc_hold_clear(acc_hold_clear), .triangle_sweep(triangle_sweep), .op_mode(op_mode),
    .isinc_bypass(isinc_bypass), .shape_key_enable(shape_key_enable),
    .shape_key_internal(shape_key_internal), .device_halted(device_halted)
  );

  ddsp_host_model ddsp_host_model_inst
  (
    .sclk(sclk), .port_select_n(port_select_n), .host_data(host_data),
    .host_data_oe(host_data_oe), .io_resync(io_resync), .read_line(read_line)
  );

  // ======
  // Checking
  always @(got_ev)
  begin
    samples_checked++;
    exp_w = exp_q.pop_front();
    if (got !== exp_w)
    begin
      fail_count++;
      $display("[ERR] %0t expected %h got %h", $time, exp_w, got);
    end
  end

  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    exp_q.push_back(e);
    got = g;
    -> got_ev;
    #1;
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  function automatic logic [31:0] obs();
    return {3'h0, comparator_pd, 1'b0, control_dac_pd, full_dac_pd, digital_clock_stop,
            1'b0, vco_high_gain, pll_bypass, pll_multiplier, 1'b0, acc_hold_clear,
            triangle_sweep, 1'b0, op_mode, update_strobe_oe, 1'b0, isinc_bypass,
            shape_key_enable, shape_key_internal, 4'h0};
  endfunction

  function automatic logic [31:0] rnd();
    logic [31:0] v;
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    v = seed & ~RSV & ~32'h0800_AF03;
    v[20:16] = 5'(4 + seed[31:24] % 17);
    return v;
  endfunction

  function automatic int nbytes(input int a);
    case (a)
      0, 1, 8, 11: return 2;
      2, 3, 4:     return 6;
      5:           return 4;
      6:           return 3;
      default:     return 1;
    endcase
  endfunction

  // ======
  // Bus cycles
  task automatic wr_ctrl(input logic [31:0] v, input int brk, input logic ab);
    logic [47:0] rd;
    ddsp_host_model_inst.frame({4'h0, CTRL_SER_ADDR}, {16'h0, v}, 4, cur[1], brk, ab, rd);
    if (!ab)
    begin
      @(negedge clock);
      if (!cur[8])
      begin
        update_strobe_in = 1'b1;
        repeat (10) @(negedge clock);
        update_strobe_in = 1'b0;
      end
      repeat (12) @(negedge clock);
      cur = v & ~RSV & ~32'h0000_8000;
      chk(cur & OBS, obs());
    end
  endtask

  task automatic rd_ctrl();
    logic [47:0] rd;
    ddsp_host_model_inst.frame({4'h8, CTRL_SER_ADDR}, 48'h0, 4, cur[1], -1, 1'b0, rd);
    chk(cur, rd[31:0]);
  endtask

  // ======
  // Main sequence
  initial
  begin
    logic [31:0] v;
    logic [47:0] rd;
    int n0;
    reset_n = 1'b0;
    update_strobe_in = 1'b0;
    seed = 32'h867661EC;
    cur = 32'h0060_0000;
    repeat (10) @(negedge clock);
    reset_n = 1'b1;
    repeat (10) @(negedge clock);
    chk(32'h0060_0000, obs());
    chk(32'h0, {30'h0, sdio_oe, serial_read_out_oe});
    for (int m = 0; m < 5; m++)
    begin
      v = rnd();
      v[11:9] = 3'(m);
      v[13] = (m == 2);
      v[15] = (m == 3);
      v[0] = m[0];
      n0 = clr_cnt;
      wr_ctrl(v, -1, 1'b0);
      chk(32'(n0 + int'(v[15])), 32'(clr_cnt));
      rd_ctrl();
    end
    wr_ctrl(rnd(), 20, 1'b1);
    rd_ctrl();
    wr_ctrl(rnd(), 13, 1'b0);
    rd_ctrl();
    for (int a = 0; a < 16; a++)
      if (a != 7)
      begin
        ddsp_host_model_inst.frame({a[0], 3'h0, a[3:0]}, {rnd(), 16'h5A3C}, nbytes(a),
                                   cur[1], -1, 1'b0, rd);
        if (a[0])
          chk(32'h0, rd[31:0]);
        rd_ctrl();
      end
    v = rnd();
    v[1] = 1'b1;
    wr_ctrl(v, -1, 1'b0);
    rd_ctrl();
    v[8] = 1'b1;
    wr_ctrl(v, -1, 1'b0);
    v = rnd() | 32'h0000_0102;
    wr_ctrl(v, -1, 1'b0);
    rd_ctrl();
    wr_ctrl(cur | 32'h0900_0000, -1, 1'b0);
    chk(32'h1, {31'h0, device_halted});
    ddsp_host_model_inst.frame({4'h0, CTRL_SER_ADDR}, 48'h0, 4, cur[1], -1, 1'b0, rd);
    repeat (20) @(negedge clock);
    chk(cur & OBS, obs());
    reset_n = 1'b0;
    repeat (3) @(negedge clock);
    reset_n = 1'b1;
    repeat (10) @(negedge clock);
    cur = CR_RESET;
    chk(cur & OBS, obs());
    chk(32'h0, {31'h0, device_halted});
    rd_ctrl();
    final_report();
  end

  initial
  begin
    #600000;
    fail_count++;
    $display("[ERR] %0t run timed out", $time);
    final_report();
  end
endmodule
